// *** cpu_core_pkg.sv ***
/*
  cpu_core_pkg: constants for the program counter and flags core.
  assumes: a single 100 MHz clock domain and an Avalon-MM register slave.
*/
package cpu_core_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses on a byte-addressed bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IP      = 8'h00;
  localparam logic [7:0] ADDR_FLAGS   = 8'h04;
  localparam logic [7:0] ADDR_ACC     = 8'h08;
  localparam logic [7:0] ADDR_SP      = 8'h0C;
  localparam logic [7:0] ADDR_INDEX   = 8'h10;
  localparam logic [7:0] ADDR_CMD     = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;

  // ----------------------------------------------------------------
  // flag bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_V = 7;
  localparam logic [7:0] FLAGS_ONES   = 8'h60;
  localparam logic [7:0] FLAGS_RESET  = 8'h68;

  // ----------------------------------------------------------------
  // vectors, reset values, opcodes
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_VEC_ADDR   = 16'hFFFE;
  localparam logic [15:0] BREAK_VEC_ADDR   = 16'hFFFC;
  localparam logic [15:0] MON_BREAK_VEC    = 16'hFEFC;
  localparam logic [15:0] SP_RESET         = 16'h00FF;
  localparam logic [7:0]  OP_SWI           = 8'h83;
  localparam logic [7:0]  OP_ADC_IMM       = 8'hA9;
  localparam logic [7:0]  OP_ADD_IMM       = 8'hAB;
  localparam logic [7:0]  OP_AND_IMM       = 8'hA4;
  localparam logic [7:0]  OP_AIS           = 8'hA7;
  localparam logic [7:0]  OP_AIX           = 8'hAF;
  localparam logic [7:0]  OP_CLI           = 8'h9A;
  localparam logic [7:0]  OP_SEI           = 8'h9B;
  localparam logic [7:0]  OP_RTI           = 8'h80;
  localparam logic [7:0]  OP_WAIT          = 8'h8F;
  localparam logic [7:0]  OP_STOP          = 8'h8E;
  localparam logic [7:0]  OP_JMP           = 8'hCC;
  localparam int          IMM_OP_CYCLES    = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int OSC_STAB_NS     = 40960;
  localparam int OSC_STAB_CYCLES = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // command register bits
  localparam int CMD_EXEC = 8;

  typedef enum logic [2:0] {
    ST_RESET_VEC, ST_IDLE, ST_EXEC2, ST_STACK, ST_VECTOR, ST_HALT, ST_STAB
  } core_state_t;

endpackage : cpu_core_pkg

// *** cpu_pc_flags_core.sv ***
/*
  cpu_pc_flags_core: program counter, flags register and the small set of
  operations that touch them, driven by software commands.
  assumes: Avalon-MM master on core_clk; memory vectors and operands are
  supplied as inputs; irq/break inputs are synchronous to core_clk or
  asynchronous pins (both synchronised here).
*/
// Added by the designer: the register offsets and the Avalon-MM slave port.
// Summary of operation
// - 16-bit pointer steps by one on every opcode or operand byte fetched.
// - jump and interrupt load the pointer with a target address.
// - reset loads the pointer from the vector held at the top two bytes.
// - flags register is 8 bits; bits 6 and 5 always read as one.
// - overflow flag follows two's complement overflow on adds.
// - half carry is the carry from bit 3 into bit 4 on adds.
// - mask set blocks maskable interrupts; mask clear accepts them.
// - interrupt entry stacks registers, then sets mask and fetches vector in one cycle.
// - interrupt entry never stacks the upper index byte.
// - with mask clear the highest-priority pending request is served first.
// - return from interrupt restores the stacked registers including the mask.
// - any reset sets the mask; the clear-mask, wait and stop ops clear it.
// - negative flag copies bit 7 of the result.
// - zero flag is set exactly when the result is zero.
// - carry flag takes carry out of bit 7 on addition.
// - wait clears mask and halts; interrupt exit keeps mask clear.
// - stop clears mask and halts; restart waits the oscillator delay.
// - break loads the software-interrupt opcode and the break or monitor vector.
// - break starts once the current instruction completes.
// - return from interrupt ends a break once the break request is gone.
// - stack adjust adds a sign-extended immediate, two cycles, flags untouched.
// - index adjust adds a sign-extended immediate, two cycles, flags untouched.
module cpu_pc_flags_core
  import cpu_core_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] reset_vector,
  input  wire logic [7:0]  irq_pending,
  input  wire logic        break_req,
  input  wire logic        monitor_mode,
  input  wire logic        stop_exit,
  output logic [7:0]       instr_reg,
  output logic             cpu_clk_en,
  output logic             in_break,
  output logic [2:0]       irq_ack_id
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  core_state_t  state_reg;
  logic [15:0]  ip_reg;
  logic [7:0]   flags_reg;
  logic [7:0]   acc_reg;
  logic [15:0]  sp_reg;
  logic [15:0]  index_reg;
  logic [7:0]   op_reg;
  logic [7:0]   operand_reg;
  logic [15:0]  target_reg;
  logic [7:0]   saved_flags_reg;
  logic [15:0]  saved_ip_reg;
  logic [15:0]  stab_cnt_reg;
  logic         rd_pend_reg;
  logic [7:0]   irq_s1_reg;
  logic [7:0]   irq_s2_reg;
  logic [1:0]   brk_s_reg;
  logic         stop_s1_reg;
  logic         stop_s2_reg;
  logic         halted_stop_reg;

  // irq, break and wake pins pass two flops before use; monitor_mode is used directly
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_s1_reg  <= 8'h00;
      irq_s2_reg  <= 8'h00;
      brk_s_reg   <= 2'h0;
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
    end else begin
      irq_s1_reg  <= irq_pending;
      irq_s2_reg  <= irq_s1_reg;
      brk_s_reg   <= {brk_s_reg[0], break_req};
      stop_s1_reg <= stop_exit;
      stop_s2_reg <= stop_s1_reg;
    end
  end
  logic brk_sync;
  assign brk_sync = brk_s_reg[1];

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  logic [8:0] sum;
  logic [4:0] half_sum;
  logic [7:0] and_res;
  logic       cin;
  logic [7:0] alu_flags;
  logic [7:0] alu_res;

  always_comb begin
    cin      = (op_reg == OP_ADC_IMM) ? flags_reg[FLAG_C] : 1'b0;
    sum      = {1'b0, acc_reg} + {1'b0, operand_reg} + {8'h00, cin};
    half_sum = {1'b0, acc_reg[3:0]} + {1'b0, operand_reg[3:0]} + {4'h0, cin};
    and_res  = acc_reg & operand_reg;
    alu_flags = flags_reg | FLAGS_ONES;
    alu_res   = acc_reg;
    if (op_reg == OP_AND_IMM) begin
      alu_res            = and_res;
      alu_flags[FLAG_V]  = 1'b0;
      alu_flags[FLAG_N]  = and_res[7];
      alu_flags[FLAG_Z]  = (and_res == 8'h00);
    end else if (op_reg == OP_ADD_IMM || op_reg == OP_ADC_IMM) begin
      alu_res            = sum[7:0];
      alu_flags[FLAG_V]  = (acc_reg[7] == operand_reg[7]) &&
                           (sum[7] != acc_reg[7]);
      alu_flags[FLAG_H]  = half_sum[4];
      alu_flags[FLAG_N]  = sum[7];
      alu_flags[FLAG_Z]  = (sum[7:0] == 8'h00);
      alu_flags[FLAG_C]  = sum[8];
    end
  end

  // highest priority request is the lowest index
  logic       irq_any;
  logic [2:0] irq_sel;
  always_comb begin
    irq_any = 1'b0;
    irq_sel = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (irq_s2_reg[i]) begin
        irq_any = 1'b1;
        irq_sel = 3'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: writes done in one cycle, reads answer a cycle later
  // ----------------------------------------------------------------
  logic wr_cmd;
  logic wr_ip;
  logic wr_flags;
  logic wr_acc;
  logic wr_sp;
  logic wr_index;
  assign avs_waitrequest = avs_read & ~rd_pend_reg;
  assign wr_cmd   = avs_write && avs_address == ADDR_CMD && state_reg == ST_IDLE &&
                    avs_writedata[CMD_EXEC];
  assign wr_ip    = avs_write && avs_address == ADDR_IP;
  assign wr_flags = avs_write && avs_address == ADDR_FLAGS;
  assign wr_acc   = avs_write && avs_address == ADDR_ACC;
  assign wr_sp    = avs_write && avs_address == ADDR_SP;
  assign wr_index = avs_write && avs_address == ADDR_INDEX;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_pend_reg  <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_pend_reg <= avs_read & ~rd_pend_reg;
      case (avs_address)
        ADDR_IP:     avs_readdata <= {16'h0000, ip_reg};
        ADDR_FLAGS:  avs_readdata <= {24'h000000, flags_reg | FLAGS_ONES};
        ADDR_ACC:    avs_readdata <= {24'h000000, acc_reg};
        ADDR_SP:     avs_readdata <= {16'h0000, sp_reg};
        ADDR_INDEX:  avs_readdata <= {16'h0000, index_reg};
        ADDR_STATUS: avs_readdata <= {24'h000000, in_break, cpu_clk_en, 3'h0, state_reg};
        default:     avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic take_irq;
  assign take_irq = irq_any && !flags_reg[FLAG_I];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg       <= ST_RESET_VEC;
      ip_reg          <= 16'h0000;
      flags_reg       <= FLAGS_RESET;
      acc_reg         <= 8'h00;
      sp_reg          <= SP_RESET;
      index_reg       <= 16'h0000;
      op_reg          <= 8'h00;
      operand_reg     <= 8'h00;
      target_reg      <= 16'h0000;
      saved_flags_reg <= FLAGS_RESET;
      saved_ip_reg    <= 16'h0000;
      stab_cnt_reg    <= 16'h0000;
      instr_reg       <= 8'h00;
      in_break        <= 1'b0;
      irq_ack_id      <= 3'h0;
      halted_stop_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RESET_VEC: begin
          ip_reg    <= reset_vector;
          state_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          if (brk_sync && !in_break) begin
            instr_reg    <= OP_SWI;
            in_break     <= 1'b1;
            target_reg   <= monitor_mode ? MON_BREAK_VEC : BREAK_VEC_ADDR;
            state_reg    <= ST_STACK;
          end else if (take_irq) begin
            irq_ack_id   <= irq_sel;
            target_reg   <= 16'hFFF0 - {12'h000, irq_sel, 1'b0};
            state_reg    <= ST_STACK;
          end else if (wr_cmd) begin
            op_reg       <= avs_writedata[7:0];
            instr_reg    <= avs_writedata[7:0];
            operand_reg  <= avs_writedata[23:16];
            target_reg   <= avs_writedata[31:16];
            ip_reg       <= ip_reg + 16'h0001;
            state_reg    <= ST_EXEC2;
          end else begin
            if (wr_ip)    ip_reg    <= avs_writedata[15:0];
            if (wr_acc)   acc_reg   <= avs_writedata[7:0];
            if (wr_sp)    sp_reg    <= avs_writedata[15:0];
            if (wr_index) index_reg <= avs_writedata[15:0];
            // software may not clear the mask through a direct write
            if (wr_flags) flags_reg <= (avs_writedata[7:0] & ~(8'h01 << FLAG_I)) |
                                       (flags_reg & (8'h01 << FLAG_I)) | FLAGS_ONES;
          end
        end
        ST_EXEC2: begin
          state_reg <= ST_IDLE;
          case (op_reg)
            OP_ADD_IMM, OP_ADC_IMM, OP_AND_IMM: begin
              ip_reg    <= ip_reg + 16'h0001;
              acc_reg   <= alu_res;
              flags_reg <= alu_flags;
            end
            OP_AIS: begin
              ip_reg <= ip_reg + 16'h0001;
              sp_reg <= sp_reg + {{8{operand_reg[7]}}, operand_reg};
            end
            OP_AIX: begin
              ip_reg    <= ip_reg + 16'h0001;
              index_reg <= index_reg + {{8{operand_reg[7]}}, operand_reg};
            end
            OP_JMP:  ip_reg <= target_reg;
            OP_CLI:  flags_reg[FLAG_I] <= 1'b0;
            OP_SEI:  flags_reg[FLAG_I] <= 1'b1;
            OP_RTI: begin
              flags_reg <= saved_flags_reg | FLAGS_ONES;
              ip_reg    <= saved_ip_reg;
              sp_reg    <= sp_reg + 16'h0003;
              if (!brk_sync) in_break <= 1'b0;
            end
            OP_WAIT, OP_STOP: begin
              flags_reg[FLAG_I] <= 1'b0;
              halted_stop_reg   <= (op_reg == OP_STOP);
              state_reg         <= ST_HALT;
            end
            default: ;
          endcase
        end
        ST_STACK: begin
          // index high byte is deliberately left off the stack
          saved_flags_reg <= flags_reg;
          saved_ip_reg    <= ip_reg;
          sp_reg          <= sp_reg - 16'h0003;
          state_reg       <= ST_VECTOR;
        end
        ST_VECTOR: begin
          flags_reg[FLAG_I] <= 1'b1;
          ip_reg            <= target_reg;
          state_reg         <= ST_IDLE;
        end
        ST_HALT: begin
          // mask stays clear on interrupt exit
          if (halted_stop_reg && stop_s2_reg) begin
            stab_cnt_reg <= 16'(OSC_STAB_CYCLES);
            state_reg    <= ST_STAB;
          end else if (!halted_stop_reg && irq_any) begin
            state_reg    <= ST_IDLE;
          end
        end
        ST_STAB: begin
          if (stab_cnt_reg <= 16'h0001) state_reg <= ST_IDLE;
          else stab_cnt_reg <= stab_cnt_reg - 16'h0001;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign cpu_clk_en = (state_reg != ST_HALT) && (state_reg != ST_STAB);

endmodule // cpu_pc_flags_core

// *** cpu_core_sva.sv ***
/*
  cpu_core_sva: port checker for cpu_pc_flags_core.
  assumes: one clock, rst synchronous active high, bound to the core below.
*/
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module cpu_core_sva
  import cpu_core_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        break_req,
  input wire logic        stop_exit,
  input wire logic [7:0]  instr_reg,
  input wire logic        cpu_clk_en,
  input wire logic        in_break
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] exit_cnt;
  // counted from the raw wake pin; the synchroniser only lengthens it
  always_ff @(posedge core_clk) begin
    if (rst || cpu_clk_en) begin
      exit_cnt <= 16'h0000;
    end else if (stop_exit || exit_cnt != 16'h0000) begin
      exit_cnt <= exit_cnt + 16'h0001;
    end
  end
  sequence rd_req; $rose(avs_read); endsequence
  sequence rd_answer; avs_waitrequest ##1 !avs_waitrequest; endsequence
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  read_answer_a: assert property (rd_req |-> rd_answer)
    else $error("read not answered after one wait cycle");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> instr_reg == 8'h00 && !in_break && avs_readdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");
  reset_run_a: assert property ($fell(rst) |-> cpu_clk_en [*2])
    else $error("core clock not running after reset");
  flag_ones_a: assert property (avs_read && !avs_waitrequest
    && avs_address == ADDR_FLAGS |-> avs_readdata[6:5] == 2'b11)
    else $error("flags bits 6 and 5 not one");
  break_entry_a: assert property ($rose(in_break) |-> instr_reg == OP_SWI)
    else $error("break entered without the software interrupt opcode");
  break_cause_a: assert property ($rose(in_break) |-> $past(break_req))
    else $error("break entered with no request");
  break_end_a: assert property ($fell(in_break) |-> !break_req)
    else $error("break ended while still requested");
  stop_delay_a: assert property ($rose(cpu_clk_en) && exit_cnt != 16'h0000
    |-> exit_cnt >= OSC_STAB_CYCLES)
    else $error("clock restarted before the stabilisation delay");
endmodule // cpu_core_sva
bind cpu_pc_flags_core cpu_core_sva cpu_core_sva_i (.core_clk(core_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .break_req(break_req),
  .stop_exit(stop_exit), .instr_reg(instr_reg), .cpu_clk_en(cpu_clk_en),
  .in_break(in_break));

// *** cpu_env_model.sv ***
/*
  cpu_env_model: reset vector memory, interrupt sources and break logic.
  assumes: set is called by the bench right after a rising edge of core_clk.
*/
// ------------------------------------------------------------
// far-side model
// ------------------------------------------------------------
module cpu_env_model #(
  parameter logic [15:0] RST_VEC = 16'hC000
) (
  input  wire logic   core_clk,
  input  wire logic   in_break,
  output logic [15:0] reset_vector,
  output logic [7:0]  irq_pending,
  output logic        break_req,
  output logic        monitor_mode,
  output logic        stop_exit
);
  timeunit 1ns;
  timeprecision 1ps;
  // vector bytes are read-only, so a constant stands for them
  assign reset_vector = RST_VEC;
  initial begin
    irq_pending  = 8'h00;
    break_req    = 1'b0;
    monitor_mode = 1'b0;
    stop_exit    = 1'b0;
  end
  // break logic lets go once the break is under way, so a return can end it
  always @(posedge core_clk) begin
    if (in_break) begin
      break_req <= 1'b0;
    end
  end
  task automatic set(input logic [7:0] irq, input logic brk, input logic mon,
                     input logic wake);
    irq_pending  <= irq;
    break_req    <= brk;
    monitor_mode <= mon;
    stop_exit    <= wake;
  endtask
endmodule // cpu_env_model

// *** cpu_pc_flags_core_tb.sv ***
/*
  cpu_pc_flags_core_tb: register-level tests of the core over Avalon-MM.
  assumes: cpu_env_model drives the vector, interrupt, break and wake inputs.
*/
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module cpu_pc_flags_core_tb
  import cpu_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [7:0] op, acc, imm, res, flg; } alu_case_t;
  localparam logic [15:0] VEC = 16'hC000;
  localparam alu_case_t ALU [4] = '{'{OP_ADD_IMM, 8'h80, 8'h80, 8'h00, 8'hEB},
    '{OP_AND_IMM, 8'hF0, 8'h8F, 8'h80, 8'h6D}, '{OP_ADC_IMM, 8'h0F, 8'h00, 8'h10, 8'h78},
    '{OP_ADD_IMM, 8'h78, 8'h08, 8'h80, 8'hFC}};
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, break_req, monitor_mode, stop_exit, cpu_clk_en, in_break;
  logic [15:0] reset_vector;
  logic [7:0]  irq_pending, instr_reg;
  logic [2:0]  irq_ack_id;
  int          bad_count = 0;
  int          cmp_count = 0;
  always #5 core_clk = ~core_clk;
  cpu_env_model #(.RST_VEC(VEC)) cpu_env_model_i (.core_clk(core_clk), .in_break(in_break),
    .reset_vector(reset_vector), .irq_pending(irq_pending), .break_req(break_req),
    .monitor_mode(monitor_mode), .stop_exit(stop_exit));
  cpu_pc_flags_core cpu_pc_flags_core_i (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reset_vector(reset_vector),
    .irq_pending(irq_pending), .break_req(break_req), .monitor_mode(monitor_mode),
    .stop_exit(stop_exit), .instr_reg(instr_reg), .cpu_clk_en(cpu_clk_en),
    .in_break(in_break), .irq_ack_id(irq_ack_id));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // entered just after a rising edge; answer taken at the edge waitrequest is low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    `CHK(s, e, q)
  endtask
  // commands are refused unless idle, so every command sent through cmd is followed by a poll
  task automatic poll();
    logic [31:0] q;
    int n;
    n = 0;
    repeat (12) @(posedge core_clk);
    do begin
      bus(ADDR_STATUS, 1'b0, 32'h0, q);
      n++;
    end while (q[2:0] !== 3'h1 && n < 3000);
    if (n >= 3000) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] hi);
    wr(ADDR_CMD, {hi, 7'h00, 1'b1, op});
    poll();
  endtask
  initial begin
    int n;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(ADDR_IP, {16'h0, VEC}, "ip after reset");
    rd(ADDR_FLAGS, 32'h68, "flags after reset");
    wr(ADDR_FLAGS, 32'h0);
    rd(ADDR_FLAGS, 32'h68, "mask kept");
    rd(8'hFC, 32'h0, "unmapped");
    foreach (ALU[i]) begin
      wr(ADDR_ACC, {24'h0, ALU[i].acc});
      cmd(ALU[i].op, {8'h00, ALU[i].imm});
      rd(ADDR_ACC, {24'h0, ALU[i].res}, "result");
      rd(ADDR_FLAGS, {24'h0, ALU[i].flg}, "flags");
    end
    rd(ADDR_IP, {16'h0, VEC + 16'h0008}, "ip step");
    cmd(OP_AIS, 16'h00FE);
    rd(ADDR_SP, 32'h00FD, "stack adjust");
    wr(ADDR_INDEX, 32'h12FF);
    cmd(OP_AIX, 16'h0002);
    rd(ADDR_INDEX, 32'h1301, "index adjust");
    rd(ADDR_FLAGS, 32'hFC, "flags untouched");
    cpu_env_model_i.set(8'h0A, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge core_clk);
    rd(ADDR_IP, {16'h0, VEC + 16'h000C}, "masked irq");
    cmd(OP_JMP, 16'h2000);
    rd(ADDR_IP, 32'h2000, "jump");
    cmd(OP_CLI, 16'h0000);
    `CHK("ack id", 3'h1, irq_ack_id)
    rd(ADDR_IP, 32'hFFEE, "irq vector");
    rd(ADDR_FLAGS, 32'hFC, "mask on entry");
    rd(ADDR_SP, 32'h00FA, "stacked");
    cpu_env_model_i.set(8'h00, 1'b0, 1'b0, 1'b0);
    cmd(OP_RTI, 16'h0000);
    rd(ADDR_FLAGS, 32'hF4, "mask restored");
    rd(ADDR_SP, 32'h00FD, "unstacked");
    cmd(OP_SEI, 16'h0000);
    wr(ADDR_CMD, {16'h0000, 7'h00, 1'b1, OP_WAIT});
    repeat (4) @(posedge core_clk);
    `CHK("wait halt", 1'b0, cpu_clk_en)
    cpu_env_model_i.set(8'h04, 1'b0, 1'b0, 1'b0);
    // wake, entry and vector all run without a command
    poll();
    `CHK("wait wake", 3'h2, irq_ack_id)
    cpu_env_model_i.set(8'h00, 1'b0, 1'b0, 1'b0);
    cmd(OP_RTI, 16'h0000);
    rd(ADDR_FLAGS, 32'hF4, "wait mask");
    cmd(OP_SEI, 16'h0000);
    wr(ADDR_CMD, {16'h0000, 7'h00, 1'b1, OP_STOP});
    repeat (4) @(posedge core_clk);
    `CHK("stop halt", 1'b0, cpu_clk_en)
    cpu_env_model_i.set(8'h00, 1'b0, 1'b0, 1'b1);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 6000);
    @(posedge core_clk);
    cpu_env_model_i.set(8'h00, 1'b0, 1'b0, 1'b0);
    `CHK("stop delay", 1'b1, n >= OSC_STAB_CYCLES && n < 6000)
    rd(ADDR_FLAGS, 32'hF4, "stop mask");
    for (int m = 0; m < 2; m++) begin
      cpu_env_model_i.set(8'h00, 1'b1, m[0], 1'b0);
      repeat (12) @(posedge core_clk);
      `CHK("in break", 1'b1, in_break)
      `CHK("break opcode", OP_SWI, instr_reg)
      rd(ADDR_IP, m[0] ? 32'hFEFC : 32'hFFFC, "break vector");
      cmd(OP_RTI, 16'h0000);
      `CHK("break end", 1'b0, in_break)
    end
    finish_test();
  end
endmodule // cpu_pc_flags_core_tb
